// *** core/bmc_defs.vh ***
/*
 * Shared constants for the regulator sequencing and register integrity
 * block: register offsets, field positions, reset values and timing.
 * Assumes a 20 MHz system clock and inclusion by its bare name.
 */
`ifndef BMC_DEFS_VH
`define BMC_DEFS_VH

// Register offsets and the number of monitored registers.
`define BMC_ADDR_MODE 4'h0
`define BMC_ADDR_CTRL 4'h1
`define BMC_ADDR_STATUS 4'h2
`define BMC_ADDR_IRQ 4'h3
`define BMC_ADDR_MASK 4'h4
`define BMC_ADDR_STATE 4'h5
`define BMC_NUM_CFG 3

// Mode register fields and register reset values.
`define BMC_MODE_DCM_BIT 0
`define BMC_MODE_PFM_BIT 1
`define BMC_MODE_DIS_BIT 2
`define BMC_MODE_RST 8'h00
`define BMC_CTRL_RST 8'h03
`define BMC_MASK_RST 8'h00

// Status and interrupt fields.
`define BMC_STAT_CORR_BIT 0
`define BMC_IRQ_NRDY_BIT 0
`define BMC_IRQ_SS_BIT 1
`define BMC_IRQ_PFM_BIT 2

// Regulator mode codes driven out.
`define BMC_RMODE_OFF 2'h0
`define BMC_RMODE_PWM 2'h1
`define BMC_RMODE_PFM 2'h2
`define BMC_RMODE_DCM 2'h3

// Timing.
`define BMC_CLK_HZ 20000000
`define BMC_SS_US 2220
`define BMC_POK_US 4000

`endif

// *** core/bmc_shadow_mem.v ***
/*
 * Protected shadow store of the configuration registers with registered
 * read data. Assumes one synchronous clock and active-low sync reset.
 */
`default_nettype none

module bmc_shadow_mem #(
  parameter DW = 8,
  parameter AW = 2,
  parameter DEPTH = 3
) (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_rst_n,
  // Write port.
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire [DW*DEPTH-1:0] i_rst_vals,
  // Registered read of every entry.
  output reg [DW*DEPTH-1:0] o_rdata
);

  reg [DW-1:0] mem_q [0:DEPTH-1];
  genvar g;

  // Each entry is loaded at reset or by a legitimate write only.
  generate
    for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
      always @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
          mem_q[g] <= i_rst_vals[g*DW +: DW];
          o_rdata[g*DW +: DW] <= i_rst_vals[g*DW +: DW];
        end else begin
          if (i_we && i_waddr == g) begin
            mem_q[g] <= i_wdata;
          end
          o_rdata[g*DW +: DW] <= mem_q[g];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// *** core/bmc_sync2.v ***
/*
 * Two-flop synchroniser for a bundle of asynchronous pin levels.
 * Assumes the inputs are quasi-static compared to the clock.
 */
`default_nettype none

module bmc_sync2 #(
  parameter W = 1
) (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_rst_n,
  // Pin levels in and synchronised copies out.
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);

  reg [W-1:0] meta_q;

  // The first stage is read only by the second.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      meta_q <= {W{1'b0}};
      o_sync <= {W{1'b0}};
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

`default_nettype wire

// *** core/bmc_top.v ***
/*
 * Register integrity monitor and buck regulator sequencing control.
 * Assumes a 20 MHz clock, sync active-low reset, a simple register port
 * with read data one cycle after the strobe, and analog comparator pins.
 */
`include "bmc_defs.vh"
`default_nettype none

module bmc_top #(
  parameter integer SS_CYC = (`BMC_SS_US * (`BMC_CLK_HZ / 1000000)),
  parameter integer POK_CYC = (`BMC_POK_US * (`BMC_CLK_HZ / 1000000))
) (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_rst_n,
  // Register port.
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // Analog and pin inputs, asynchronous.
  input wire i_supply_ok,
  input wire i_out_above_95,
  input wire i_out_above_103,
  input wire i_out_above_101,
  input wire i_switch_rate_select_pin,
  input wire i_reset_pin_n,
  // Fault injection onto live register bits.
  input wire [7:0] i_upset_mask,
  input wire [1:0] i_upset_sel,
  // Regulator control.
  output reg o_reg_enable,
  output reg [1:0] o_reg_mode,
  output reg o_switch_node_gate,
  output reg o_rate_high,
  // Drivers, interrupt and reset output.
  output reg o_line_drv_en,
  output reg o_aux_io_driver_en,
  output reg o_irq_n,
  output reg o_reset_out_oe
);

  localparam [3:0] ST_OFF = 4'h1;
  localparam [3:0] ST_SOFT = 4'h2;
  localparam [3:0] ST_RUN = 4'h4;
  localparam [3:0] ST_DIS = 4'h8;
  localparam [15:0] SS_W = SS_CYC[15:0];
  localparam [16:0] POK_W = POK_CYC[16:0];

  wire [5:0] pins_s;
  wire [23:0] shadow;
  wire supply_ok = pins_s[0];
  wire above_95 = pins_s[1];
  wire above_103 = pins_s[2];
  wire above_101 = pins_s[3];
  wire rate_pin = pins_s[4];
  wire rst_pin_n = pins_s[5];

  reg [7:0] mode_q;
  reg [7:0] ctrl_q;
  reg [7:0] mask_q;
  reg corrupted_register_flag_q;
  reg not_ready_flag_q;
  reg ss_done_q;
  reg pfm_evt_q;
  reg [3:0] st_q;
  reg [15:0] ss_cnt_q;
  reg [16:0] pok_cnt_q;
  reg pfm_stop_q;
  reg [7:0] rdata_d;
  reg mismatch;
  reg [1:0] rmode_sel;

  wire cfg_wr = i_wr && (i_addr == `BMC_ADDR_MODE ||
    i_addr == `BMC_ADDR_CTRL || i_addr == `BMC_ADDR_MASK);
  // Shadow slot of a monitored register; the mask sits in slot two.
  wire [1:0] cfg_idx = (i_addr == `BMC_ADDR_MASK) ? 2'h2 : i_addr[1:0];
  wire regulator_disable_bit = mode_q[`BMC_MODE_DIS_BIT];
  wire discontinuous_select_bit = mode_q[`BMC_MODE_DCM_BIT];
  wire pulse_frequency_select_bit = mode_q[`BMC_MODE_PFM_BIT];
  wire rd_irq = i_rd && i_addr == `BMC_ADDR_IRQ;
  wire [7:0] irq_vec = {5'h00, pfm_evt_q, ss_done_q, not_ready_flag_q};

  // Synchronise the asynchronous comparator and pin levels.
  bmc_sync2 #(
    .W(6)
  ) u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_reset_pin_n, i_switch_rate_select_pin, i_out_above_101,
      i_out_above_103, i_out_above_95, i_supply_ok}),
    .o_sync(pins_s)
  );

  // Protected copy of the configuration registers.
  bmc_shadow_mem #(
    .DW(8),
    .AW(2),
    .DEPTH(`BMC_NUM_CFG)
  ) u_shadow (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_we(cfg_wr),
    .i_waddr(cfg_idx),
    .i_wdata(i_wdata),
    .i_rst_vals({`BMC_MASK_RST, `BMC_CTRL_RST, `BMC_MODE_RST}),
    .o_rdata(shadow)
  );

  // Live registers; upsets model disturbances flipping stored bits.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      mode_q <= `BMC_MODE_RST;
      ctrl_q <= `BMC_CTRL_RST;
      mask_q <= `BMC_MASK_RST;
    end else begin
      if (i_wr && i_addr == `BMC_ADDR_MODE) begin
        mode_q <= i_wdata;
      end else if (i_upset_sel == 2'h1) begin
        mode_q <= mode_q ^ i_upset_mask;
      end
      if (i_wr && i_addr == `BMC_ADDR_CTRL) begin
        ctrl_q <= i_wdata;
      end else if (i_upset_sel == 2'h2) begin
        ctrl_q <= ctrl_q ^ i_upset_mask;
      end
      if (i_wr && i_addr == `BMC_ADDR_MASK) begin
        mask_q <= i_wdata;
      end else if (i_upset_sel == 2'h3) begin
        mask_q <= mask_q ^ i_upset_mask;
      end
    end
  end

  // Compare every live bit against the shadow each cycle; the shadow
  // lags a write by two cycles, so compare only when no write is recent.
  reg [1:0] wr_age_q;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      wr_age_q <= 2'h3;
    end else if (cfg_wr) begin
      wr_age_q <= 2'h0;
    end else if (wr_age_q != 2'h3) begin
      wr_age_q <= wr_age_q + 2'h1;
    end
  end

  always @* begin
    mismatch = 1'b0;
    if (wr_age_q == 2'h3 && !cfg_wr) begin
      mismatch = (mode_q != shadow[7:0]) ||
        (ctrl_q != shadow[15:8]) || (mask_q != shadow[23:16]);
    end
  end

  // Corrupt flag follows the comparison: set on mismatch, cleared by
  // hardware once all values are restored by host rewrites.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      corrupted_register_flag_q <= 1'b0;
    end else if (mismatch) begin
      corrupted_register_flag_q <= 1'b1;
    end else if (wr_age_q == 2'h3 && !cfg_wr) begin
      corrupted_register_flag_q <= 1'b0;
    end
  end

  // Sticky interrupt flags; a set in the same cycle as a clear wins.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      not_ready_flag_q <= 1'b0;
      ss_done_q <= 1'b0;
      pfm_evt_q <= 1'b0;
    end else begin
      if (mismatch || corrupted_register_flag_q) begin
        not_ready_flag_q <= 1'b1;
      end else if (rd_irq) begin
        not_ready_flag_q <= 1'b0;
      end
      if (st_q == ST_SOFT && (above_95 || ss_cnt_q == SS_W)) begin
        ss_done_q <= 1'b1;
      end else if (i_wr && i_addr == `BMC_ADDR_IRQ &&
          i_wdata[`BMC_IRQ_SS_BIT]) begin
        ss_done_q <= 1'b0;
      end
      if (o_reg_mode == `BMC_RMODE_PFM && above_103 && !pfm_stop_q) begin
        pfm_evt_q <= 1'b1;
      end else if (i_wr && i_addr == `BMC_ADDR_IRQ &&
          i_wdata[`BMC_IRQ_PFM_BIT]) begin
        pfm_evt_q <= 1'b0;
      end
    end
  end

  // Regulator sequencer: off, soft-start in discontinuous, run, disabled.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      st_q <= ST_OFF;
      ss_cnt_q <= 16'h0000;
    end else begin
      case (st_q)
        ST_OFF: begin
          ss_cnt_q <= 16'h0000;
          if (regulator_disable_bit) begin
            st_q <= ST_DIS;
          end else if (supply_ok) begin
            st_q <= ST_SOFT;
          end
        end
        ST_SOFT: begin
          if (ss_cnt_q != SS_W) begin
            ss_cnt_q <= ss_cnt_q + 16'h0001;
          end
          if (regulator_disable_bit) begin
            st_q <= ST_DIS;
          end else if (!supply_ok) begin
            st_q <= ST_OFF;
          end else if (above_95 || ss_cnt_q == SS_W) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (regulator_disable_bit) begin
            st_q <= ST_DIS;
          end else if (!supply_ok) begin
            st_q <= ST_OFF;
          end
        end
        ST_DIS: begin
          if (!regulator_disable_bit) begin
            st_q <= ST_OFF;
          end
        end
        default: begin
          st_q <= ST_OFF;
        end
      endcase
    end
  end

  // Normal-mode decode; the discontinuous bit overrides.
  always @* begin
    if (discontinuous_select_bit) begin
      rmode_sel = `BMC_RMODE_DCM;
    end else if (pulse_frequency_select_bit) begin
      rmode_sel = `BMC_RMODE_PFM;
    end else begin
      rmode_sel = `BMC_RMODE_PWM;
    end
  end

  // Pulse-frequency hysteresis between the 103 and 101 percent levels.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pfm_stop_q <= 1'b0;
    end else if (o_reg_mode != `BMC_RMODE_PFM) begin
      pfm_stop_q <= 1'b0;
    end else if (above_103) begin
      pfm_stop_q <= 1'b1;
    end else if (!above_101) begin
      pfm_stop_q <= 1'b0;
    end
  end

  // Reset-output release delay, restarted on each pin release.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      pok_cnt_q <= 17'h00000;
    end else begin
      if (!rst_pin_n || !supply_ok) begin
        pok_cnt_q <= 17'h00000;
      end else if (pok_cnt_q != POK_W) begin
        pok_cnt_q <= pok_cnt_q + 17'h00001;
      end
    end
  end

  // Registered outputs.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_reg_enable <= 1'b0;
      o_reg_mode <= `BMC_RMODE_OFF;
      o_switch_node_gate <= 1'b0;
      o_rate_high <= 1'b0;
      o_line_drv_en <= 1'b0;
      o_aux_io_driver_en <= 1'b0;
      o_irq_n <= 1'b1;
      o_reset_out_oe <= 1'b1;
    end else begin
      o_reg_enable <= (st_q == ST_SOFT) || (st_q == ST_RUN);
      if (st_q == ST_SOFT) begin
        o_reg_mode <= `BMC_RMODE_DCM;
      end else if (st_q == ST_RUN) begin
        o_reg_mode <= rmode_sel;
      end else begin
        o_reg_mode <= `BMC_RMODE_OFF;
      end
      o_switch_node_gate <= ((st_q == ST_SOFT) || (st_q == ST_RUN)) &&
        !(o_reg_mode == `BMC_RMODE_PFM && pfm_stop_q);
      o_rate_high <= rate_pin;
      o_line_drv_en <= ctrl_q[0] && !not_ready_flag_q && !mismatch;
      o_aux_io_driver_en <= ctrl_q[1] && !not_ready_flag_q &&
        !mismatch;
      o_irq_n <= !((|(irq_vec & ~mask_q)) ||
        (mismatch && !mask_q[`BMC_IRQ_NRDY_BIT]));
      if (!rst_pin_n || !supply_ok) begin
        o_reset_out_oe <= 1'b1;
      end else if (regulator_disable_bit) begin
        o_reset_out_oe <= (pok_cnt_q != POK_W);
      end else begin
        o_reset_out_oe <= 1'b0;
      end
    end
  end

  // Read mux; unmapped addresses read zero.
  always @* begin
    rdata_d = 8'h00;
    if (i_addr == `BMC_ADDR_MODE) begin
      rdata_d = mode_q;
    end else if (i_addr == `BMC_ADDR_CTRL) begin
      rdata_d = ctrl_q;
    end else if (i_addr == `BMC_ADDR_STATUS) begin
      rdata_d = {7'h00, corrupted_register_flag_q};
    end else if (i_addr == `BMC_ADDR_IRQ) begin
      rdata_d = irq_vec;
    end else if (i_addr == `BMC_ADDR_MASK) begin
      rdata_d = mask_q;
    end else if (i_addr == `BMC_ADDR_STATE) begin
      rdata_d = {4'h0, st_q};
    end
  end

  // Read data stand one cycle after the strobe and read zero otherwise.
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// *** test/bmc_host_model.sv ***
/* Host controller model driving the block's register port.
   Assumes read data one cycle after the read strobe and no wait. */
`include "bmc_defs.vh"
`default_nettype none
module bmc_host_model (
  // Clock.
  input wire logic i_sys_clk,
  // Register port toward the block.
  output var logic [3:0] o_addr,
  output var logic [7:0] o_wdata,
  output var logic o_wr,
  output var logic o_rd,
  input wire logic [7:0] i_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // The bus idles with both strobes low.
  initial begin
    o_addr = 4'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_wdata <= v;
    o_wr <= 1'b1;
    @(posedge i_sys_clk);
    o_wr <= 1'b0;
  endtask

  // One-cycle read strobe; data is taken in the following cycle.
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge i_sys_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_sys_clk);
    o_rd <= 1'b0;
    #1 v = i_rdata;
  endtask

  // Writes every monitored register back with its intended value.
  task automatic restore(input logic [7:0] mode);
    wr(`BMC_ADDR_MODE, mode);
    wr(`BMC_ADDR_CTRL, `BMC_CTRL_RST);
    wr(`BMC_ADDR_MASK, `BMC_MASK_RST);
  endtask
endmodule
`default_nettype wire

// *** test/bmc_chk_assertions.sv ***
/* Concurrent checks on the regulator and integrity block.
   Bound to bmc_top and sees only its ports. */
`include "bmc_defs.vh"
`default_nettype none
module bmc_chk (
  // Clock, reset and register port.
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  // Pins and fault injection.
  input wire logic i_supply_ok,
  input wire logic i_out_above_103,
  input wire logic i_out_above_101,
  input wire logic i_switch_rate_select_pin,
  input wire logic i_reset_pin_n,
  input wire logic [7:0] i_upset_mask,
  input wire logic [1:0] i_upset_sel,
  // Regulator, drivers and interrupt.
  input wire logic o_reg_enable,
  input wire logic [1:0] o_reg_mode,
  input wire logic o_switch_node_gate,
  input wire logic o_rate_high,
  input wire logic o_line_drv_en,
  input wire logic o_aux_io_driver_en,
  input wire logic o_irq_n,
  input wire logic o_reset_out_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // All checks use the system clock and pause in reset.
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // An upset that flips at least one live bit, and pulse mode.
  wire logic upset = (i_upset_sel != 2'h0) && (i_upset_mask != 8'h00);
  wire logic pulse_frequency_mode = (o_reg_mode == `BMC_RMODE_PFM);
  wire logic mwr = i_wr && (i_addr == `BMC_ADDR_MODE);

  // Last disable bit written, to tell the two release cases apart.
  logic dis_q;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      dis_q <= 1'b0;
    end else if (mwr) begin
      dis_q <= i_wdata[`BMC_MODE_DIS_BIT];
    end
  end

  a_upset_irq: assert property (upset |-> ##[1:3] !o_irq_n)
    else $error("interrupt not raised after register upset");
  a_upset_drv: assert property (upset |-> ##[1:3]
    (!o_line_drv_en && !o_aux_io_driver_en))
    else $error("drivers left on after register upset");
  a_dis_off: assert property (mwr && i_wdata[2] |-> ##3
    (!o_reg_enable && o_reg_mode == `BMC_RMODE_OFF))
    else $error("regulator still on after disable write");
  a_dcm_wins: assert property (mwr && i_wdata[0] && !i_wdata[2]
    && o_reg_enable |-> ##[1:3] o_reg_mode == `BMC_RMODE_DCM)
    else $error("discontinuous select did not win");
  a_rate_copy: assert property ($stable(i_switch_rate_select_pin)[*4]
    |-> o_rate_high == i_switch_rate_select_pin)
    else $error("rate output does not follow the pin");
  a_pfm_stop: assert property ((pulse_frequency_mode && i_out_above_103)[*5]
    |-> !o_switch_node_gate)
    else $error("switching not stopped above upper level");
  a_pfm_go: assert property ((pulse_frequency_mode && !i_out_above_101)[*5]
    |-> o_switch_node_gate)
    else $error("switching not resumed below lower level");
  a_rst_fast: assert property ($rose(i_reset_pin_n) && i_supply_ok
    && !dis_q |-> ##[1:5] !o_reset_out_oe)
    else $error("reset output not released promptly");
  a_rst_slow: assert property ($rose(i_reset_pin_n) && i_supply_ok
    && dis_q |-> ##5 o_reset_out_oe)
    else $error("reset output released early while disabled");

  // Main scenarios reached.
  c_soft: cover property (o_reg_mode == `BMC_RMODE_DCM);
  c_irq: cover property (upset ##1 !o_irq_n);
  c_stop: cover property (pulse_frequency_mode && !o_switch_node_gate);
endmodule
bind bmc_top bmc_chk u_chk (.*);
`default_nettype wire

// *** test/tb_buck_mode_ctrl_reg_integrity.sv ***
/* Self-checking bench for the regulator and integrity block.
   Uses the host model for register traffic and short timing counts. */
`include "bmc_defs.vh"
`default_nettype none
module tb_buck_mode_ctrl_reg_integrity;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SS = 50;
  localparam int POK = 100;
  logic i_sys_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_supply_ok = 1'b0;
  logic i_out_above_95 = 1'b0;
  logic i_out_above_103 = 1'b0;
  logic i_out_above_101 = 1'b0;
  logic i_switch_rate_select_pin = 1'b0;
  logic i_reset_pin_n = 1'b1;
  logic [7:0] i_upset_mask = 8'h00;
  logic [1:0] i_upset_sel = 2'h0;
  wire logic [3:0] i_addr;
  wire logic [7:0] i_wdata;
  wire logic [7:0] o_rdata;
  wire logic i_wr, i_rd, o_reg_enable, o_switch_node_gate, o_rate_high;
  wire logic o_line_drv_en, o_aux_io_driver_en, o_irq_n, o_reset_out_oe;
  wire logic [1:0] o_reg_mode;
  logic [7:0] mexp [4] = '{8'h01, 8'h03, 8'h02, 8'h03};
  logic [7:0] d;
  int fails = 0;
  int num_checks = 0;

  // Free-running 20 MHz clock.
  initial begin
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  bmc_top #(.SS_CYC(SS), .POK_CYC(POK)) dut (.*);
  bmc_host_model host (.i_sys_clk, .o_addr(i_addr), .o_wdata(i_wdata),
    .o_wr(i_wr), .o_rd(i_rd), .i_rdata(o_rdata));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    host.rd(a, v);
    chk(v, exp);
  endtask

  // Lets n edges pass and samples after their updates settle.
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  // Waits a bounded time for a regulator mode, then compares it.
  task automatic waitm(input logic [1:0] m, input int n);
    for (int i = 0; i < n && o_reg_mode !== m; i++) tick(1);
    chk({6'h0, o_reg_mode}, {6'h0, m});
  endtask

  task automatic test_done;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    fails++;
    test_done();
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rdchk(`BMC_ADDR_MODE, `BMC_MODE_RST);
    rdchk(`BMC_ADDR_CTRL, `BMC_CTRL_RST);
    rdchk(`BMC_ADDR_MASK, `BMC_MASK_RST);
    host.wr(`BMC_ADDR_STATUS, 8'hff);
    rdchk(`BMC_ADDR_STATUS, 8'h00);
    rdchk(4'hf, 8'h00);
    host.rd(`BMC_ADDR_IRQ, d);
    chk({7'h0, o_rate_high}, 8'h00);
    // Supply comes up: soft start, then timeout into the default mode.
    @(posedge i_sys_clk) i_supply_ok <= 1'b1;
    waitm(`BMC_RMODE_DCM, 10);
    chk({7'h0, o_reset_out_oe}, 8'h00);
    waitm(`BMC_RMODE_PWM, SS + 20);
    // Soft-start done event: raise, mask, unmask, clear.
    tick(3);
    chk({7'h0, o_irq_n}, 8'h00);
    host.wr(`BMC_ADDR_MASK, 8'h02);
    tick(3);
    chk({7'h0, o_irq_n}, 8'h01);
    host.wr(`BMC_ADDR_MASK, 8'h00);
    host.wr(`BMC_ADDR_IRQ, 8'h02);
    tick(3);
    chk({5'h0, o_irq_n, o_aux_io_driver_en, o_line_drv_en}, 8'h07);
    // Every mode encoding.
    for (int m = 0; m < 4; m++) begin
      host.wr(`BMC_ADDR_MODE, m[7:0]);
      tick(4);
      chk({6'h0, o_reg_mode}, mexp[m]);
    end
    // Pulse mode hysteresis.
    host.wr(`BMC_ADDR_MODE, 8'h02);
    @(posedge i_sys_clk);
    i_out_above_101 <= 1'b1;
    i_out_above_103 <= 1'b1;
    tick(6);
    chk({7'h0, o_switch_node_gate}, 8'h00);
    @(posedge i_sys_clk) i_out_above_103 <= 1'b0;
    tick(6);
    chk({7'h0, o_switch_node_gate}, 8'h00);
    @(posedge i_sys_clk) i_out_above_101 <= 1'b0;
    tick(6);
    chk({7'h0, o_switch_node_gate}, 8'h01);
    @(posedge i_sys_clk) i_switch_rate_select_pin <= 1'b1;
    tick(5);
    chk({7'h0, o_rate_high}, 8'h01);
    host.wr(`BMC_ADDR_IRQ, 8'h06);
    // Upset one control bit while the monitor is quiet.
    tick(5);
    @(posedge i_sys_clk);
    i_upset_sel <= 2'h2;
    i_upset_mask <= 8'h01;
    @(posedge i_sys_clk);
    i_upset_sel <= 2'h0;
    i_upset_mask <= 8'h00;
    tick(2);
    chk({5'h0, o_irq_n, o_aux_io_driver_en, o_line_drv_en}, 8'h00);
    rdchk(`BMC_ADDR_STATUS, 8'h01);
    host.rd(`BMC_ADDR_IRQ, d);
    chk(d & 8'h01, 8'h01);
    host.restore(8'h02);
    tick(8);
    rdchk(`BMC_ADDR_STATUS, 8'h00);
    chk({6'h0, o_aux_io_driver_en, o_line_drv_en}, 8'h00);
    host.rd(`BMC_ADDR_IRQ, d);
    chk(d & 8'h01, 8'h01);
    tick(3);
    chk({5'h0, o_irq_n, o_aux_io_driver_en, o_line_drv_en}, 8'h07);
    // Disable and re-enable the regulator.
    host.wr(`BMC_ADDR_MODE, 8'h04);
    tick(3);
    chk({5'h0, o_reg_enable, o_reg_mode}, 8'h00);
    host.wr(`BMC_ADDR_MODE, 8'h00);
    tick(4);
    chk({7'h0, o_reg_enable}, 8'h01);
    // Output at 95 percent ends soft-start long before the timeout.
    @(posedge i_sys_clk) i_out_above_95 <= 1'b1;
    waitm(`BMC_RMODE_PWM, 10);
    rdchk(`BMC_ADDR_STATE, 8'h04);
    // Reset pin pulse with the regulator enabled.
    @(posedge i_sys_clk) i_reset_pin_n <= 1'b0;
    tick(5);
    @(posedge i_sys_clk) i_reset_pin_n <= 1'b1;
    tick(6);
    chk({7'h0, o_reset_out_oe}, 8'h00);
    // Reset pin pulse with the regulator disabled: release is delayed.
    host.wr(`BMC_ADDR_MODE, 8'h04);
    @(posedge i_sys_clk) i_reset_pin_n <= 1'b0;
    tick(5);
    @(posedge i_sys_clk) i_reset_pin_n <= 1'b1;
    tick(6);
    chk({7'h0, o_reset_out_oe}, 8'h01);
    tick(POK);
    chk({7'h0, o_reset_out_oe}, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
